/* rtl/pulse_out_top.v */
// Dual pulse output block: Avalon-MM register slave, two generators and
// a shared time base. Assumes ref_clk at 40 MHz and a synchronous reset.
//
// Operation
// R1 - Special memory bytes monitor and control both generators.
// R2 - Status bit 4 flags a profile aborted by delta calculation error.
// R3 - Status bit 5 flags a profile aborted by user command.
// R4 - Status bit 6 flags pipeline overflow; cleared by user or profiles.
// R5 - Status bit 7 reads 1 when idle, 0 while a train runs.
// R6 - Control bit 0 loads a new cycle time in both modes.
// R7 - Control bit 1 loads a new modulation pulse width.
// R8 - Control bit 2 loads a new pulse count.
// R9 - Control bit 3 picks 1 us or 1 ms per tick.
// R10 - Control bit 4 picks asynchronous or synchronous modulation update.
// R11 - Control bit 5 picks single segment or profile table operation; the code has no profile table and only clears status bit 6 on a command.
// R12 - Control bit 6 picks pulse train or pulse width modulation.
// R13 - Control bit 7 enables the generator; clear means no output.
// R14 - Cycle time is 16 bits, valid from 2 to 65535; the code refuses lower values only in pulse train mode.
// R15 - Pulse width is 16 bits, accepted from 0 to 65535.
// R16 - Pulse count is 32 bits, never zero.
// R17 - Second generator mirrors the first at its own offsets.
// R18 - Settings are sampled only when the output command executes.
// R19 - Synchronous update waits for period end; asynchronous restarts.
`default_nettype none
`include "pulse_map.vh"

module pulse_out_top (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   output wire        pulse_out0,
   output wire        pulse_out1
);

   reg  [7:0]  ctl_reg   [0:1];
   reg  [15:0] cyc_reg   [0:1];
   reg  [15:0] wid_reg   [0:1];
   reg  [31:0] cnt_reg   [0:1];
   reg  [2:0]  flag_reg  [0:1];
   reg  [1:0]  exec_reg;
   wire [1:0]  busy;
   wire [1:0]  delta_ev;
   wire [1:0]  user_ev;
   wire [1:0]  ovf_ev;
   wire        us_tick;
   wire        ms_tick;

   // Address decode result.
   reg         hit;
   reg         gsel;
   reg  [2:0]  field;
   reg  [31:0] rd_next;
   reg  [2:0]  flag_next [0:1];
   integer     g;
   integer     k;

   localparam F_STATUS = 3'h0;
   localparam F_CTL    = 3'h1;
   localparam F_CYC    = 3'h2;
   localparam F_WID    = 3'h3;
   localparam F_CNT    = 3'h4;
   localparam F_EXEC   = 3'h5;

   wire access = (avs_read | avs_write) & avs_waitrequest;
   wire wr     = avs_write & avs_waitrequest;

   // Byte-lane merge so partial writes leave other lanes untouched.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] new_val;
      input [3:0]  be;
      integer      b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) begin
               merge[b*8 +: 8] = new_val[b*8 +: 8];
            end
         end
      end
   endfunction

   // Lane-merged word values; only the low half is kept on purpose.
   wire [31:0] cyc_merged = merge({16'h0000, cyc_reg[gsel]}, avs_writedata,
                                  avs_byteenable);
   wire [31:0] wid_merged = merge({16'h0000, wid_reg[gsel]}, avs_writedata,
                                  avs_byteenable);

   // Register index to generator and field.
   always @* begin
      hit   = 1'b1;
      gsel  = 1'b0;
      field = F_STATUS;
      case (avs_address)
         `IDX_G0_STATUS: field = F_STATUS; // R1
         `IDX_G0_CTL:    field = F_CTL;
         `IDX_G0_CYC:    field = F_CYC;
         `IDX_G0_WID:    field = F_WID;
         `IDX_G0_CNT:    field = F_CNT;
         `IDX_G1_STATUS: begin // R17
            gsel  = 1'b1;
            field = F_STATUS;
         end
         `IDX_G1_CTL: begin
            gsel  = 1'b1;
            field = F_CTL;
         end
         `IDX_G1_CYC: begin
            gsel  = 1'b1;
            field = F_CYC;
         end
         `IDX_G1_WID: begin
            gsel  = 1'b1;
            field = F_WID;
         end
         `IDX_G1_CNT: begin
            gsel  = 1'b1;
            field = F_CNT;
         end
         `IDX_EXEC:      field = F_EXEC;
         default:        hit   = 1'b0;
      endcase
   end

   // Read mux; unmapped indices and the command register read as zero.
   always @* begin
      rd_next = 32'h0000_0000;
      if (hit) begin
         case (field)
            F_STATUS: rd_next = {24'h000000, ~busy[gsel],
                                 flag_reg[gsel], 4'h0}; // R5
            F_CTL:    rd_next = {24'h000000, ctl_reg[gsel]};
            F_CYC:    rd_next = {16'h0000, cyc_reg[gsel]};
            F_WID:    rd_next = {16'h0000, wid_reg[gsel]};
            F_CNT:    rd_next = cnt_reg[gsel];
            default:  rd_next = 32'h0000_0000;
         endcase
      end
   end

   // Bus handshake: one wait cycle, then waitrequest drops for one cycle.
   always @(posedge ref_clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if (access) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_read ? rd_next : 32'h0000_0000;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Value and control registers; the generators only look at them
   // when a command pulse arrives.
   always @(posedge ref_clk) begin
      if (rst) begin
         for (g = 0; g < 2; g = g + 1) begin
            ctl_reg[g] <= `RST_BYTE;
            cyc_reg[g] <= `CYC_MIN;
            wid_reg[g] <= `RST_WORD;
            cnt_reg[g] <= `RST_DWORD;
         end
         exec_reg <= 2'b00;
      end else begin
         exec_reg <= 2'b00;
         if (wr && hit) begin
            case (field)
               F_CTL: begin
                  if (avs_byteenable[0]) begin
                     ctl_reg[gsel] <= avs_writedata[7:0];
                  end
               end
               F_CYC: cyc_reg[gsel] <= cyc_merged[15:0]; // R14
               F_WID: wid_reg[gsel] <= wid_merged[15:0]; // R15
               F_CNT: cnt_reg[gsel] <= merge(cnt_reg[gsel],
                  avs_writedata, avs_byteenable); // R16
               F_EXEC: begin
                  if (avs_byteenable[0]) begin
                     exec_reg <= avs_writedata[1:0]; // R18
                  end
               end
               default: exec_reg <= 2'b00;
            endcase
         end
      end
   end

   // Next status flags: writing 0 clears a flag, an event in the same
   // cycle still sets it so no event is lost.
   always @* begin
      for (k = 0; k < 2; k = k + 1) begin
         flag_next[k] = flag_reg[k];
         if (wr && hit && field == F_STATUS && gsel == k[0]
             && avs_byteenable[0]) begin
            flag_next[k] = flag_next[k] & avs_writedata[6:4]; // R4
         end
         if (exec_reg[k] && ctl_reg[k][`CT_MULTI]) begin
            flag_next[k][2] = 1'b0; // R4 R11
         end
         flag_next[k] = flag_next[k] | {ovf_ev[k], user_ev[k], delta_ev[k]};
      end
   end

   // Sticky status flags.
   always @(posedge ref_clk) begin
      if (rst) begin
         flag_reg[0] <= 3'b000;
         flag_reg[1] <= 3'b000;
      end else begin
         flag_reg[0] <= flag_next[0]; // R2 R3 R4
         flag_reg[1] <= flag_next[1]; // R17
      end
   end

   tick_base u_tick (
      .ref_clk (ref_clk),
      .rst     (rst),
      .us_tick (us_tick),
      .ms_tick (ms_tick)
   );

   pulse_gen u_gen0 (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .us_tick   (us_tick),
      .ms_tick   (ms_tick),
      .exec      (exec_reg[0]),
      .ctl       (ctl_reg[0]),
      .cycle_in  (cyc_reg[0]),
      .width_in  (wid_reg[0]),
      .count_in  (cnt_reg[0]),
      .pulse_out (pulse_out0),
      .busy      (busy[0]),
      .delta_ev  (delta_ev[0]),
      .user_ev   (user_ev[0]),
      .ovf_ev    (ovf_ev[0])
   );

   // Second generator is an identical copy.
   pulse_gen u_gen1 (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .us_tick   (us_tick),
      .ms_tick   (ms_tick),
      .exec      (exec_reg[1]),
      .ctl       (ctl_reg[1]),
      .cycle_in  (cyc_reg[1]),
      .width_in  (wid_reg[1]),
      .count_in  (cnt_reg[1]),
      .pulse_out (pulse_out1), // R17
      .busy      (busy[1]),
      .delta_ev  (delta_ev[1]),
      .user_ev   (user_ev[1]),
      .ovf_ev    (ovf_ev[1])
   );

endmodule // pulse_out_top
`default_nettype wire

/* rtl/pulse_map.vh */
// Register indices, field positions and timing figures for the dual
// pulse output block. Assumes a word-addressed Avalon-MM slave port.
`ifndef PULSE_MAP_VH
`define PULSE_MAP_VH

// Register indices; byte address is four times the index.
`define IDX_G0_STATUS 8'h42
`define IDX_G0_CTL    8'h43
`define IDX_G0_CYC    8'h44
`define IDX_G0_WID    8'h46
`define IDX_G0_CNT    8'h48
`define IDX_G1_STATUS 8'h4C
`define IDX_G1_CTL    8'h4D
`define IDX_G1_CYC    8'h4E
`define IDX_G1_WID    8'h50
`define IDX_G1_CNT    8'h52
`define IDX_EXEC      8'h56

// Status byte fields.
`define ST_DELTA 4
`define ST_USER  5
`define ST_OVF   6
`define ST_IDLE  7

// Control byte fields.
`define CT_UPD_CYC 0
`define CT_UPD_WID 1
`define CT_UPD_CNT 2
`define CT_TB      3
`define CT_SYNC    4
`define CT_MULTI   5
`define CT_PWM     6
`define CT_EN      7

// Limits and reset values.
`define CYC_MIN   16'h0002
`define CNT_ZERO  32'h0000_0000
`define RST_BYTE  8'h00
`define RST_WORD  16'h0000
`define RST_DWORD 32'h0000_0000

// Time base figures.
`define CLK_NS  25
`define TICK_NS 1000
`define MS_US   1000

`endif

/* rtl/tick_base.v */
// Time base for the pulse generators: one-cycle ticks every 1 us and 1 ms.
// Assumes ref_clk runs at a rate whose period divides 1 us evenly.
`default_nettype none
`include "pulse_map.vh"

module tick_base #(
   parameter US_CYC = `TICK_NS / `CLK_NS,
   parameter MS_US  = `MS_US
) (
   input  wire        ref_clk,
   input  wire        rst,
   output reg         us_tick,
   output reg         ms_tick
);

   reg [15:0] div_reg;
   reg [15:0] us_cnt_reg;

   // Two cascaded dividers keep each counter narrow.
   always @(posedge ref_clk) begin
      if (rst) begin
         div_reg    <= 16'h0000;
         us_cnt_reg <= 16'h0000;
         us_tick    <= 1'b0;
         ms_tick    <= 1'b0;
      end else begin
         us_tick <= 1'b0;
         ms_tick <= 1'b0;
         if (div_reg == US_CYC[15:0] - 16'h0001) begin
            div_reg <= 16'h0000;
            us_tick <= 1'b1;
            if (us_cnt_reg == MS_US[15:0] - 16'h0001) begin
               us_cnt_reg <= 16'h0000;
               ms_tick    <= 1'b1;
            end else begin
               us_cnt_reg <= us_cnt_reg + 16'h0001;
            end
         end else begin
            div_reg <= div_reg + 16'h0001;
         end
      end
   end

endmodule // tick_base
`default_nettype wire

/* rtl/pulse_gen.v */
// One pulse generator: pulse train of a counted number of pulses or
// pulse width modulation. Assumes exec is a one-cycle pulse from the
// register block and that ticks are one-cycle pulses.
`default_nettype none
`include "pulse_map.vh"

module pulse_gen (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        us_tick,
   input  wire        ms_tick,
   input  wire        exec,
   input  wire [7:0]  ctl,
   input  wire [15:0] cycle_in,
   input  wire [15:0] width_in,
   input  wire [31:0] count_in,
   output reg         pulse_out,
   output wire        busy,
   output reg         delta_ev,
   output reg         user_ev,
   output reg         ovf_ev
);

   reg        run_reg;
   reg        pwm_reg;
   reg        tb_reg;
   reg [15:0] cyc_reg;
   reg [15:0] wid_reg;
   reg [15:0] phase_reg;
   reg [31:0] left_reg;
   reg [31:0] cnt_last_reg;
   reg        pend_reg;
   reg [15:0] pend_cyc_reg;
   reg [15:0] pend_wid_reg;
   reg [31:0] pend_cnt_reg;

   wire        tick       = tb_reg ? ms_tick : us_tick;
   wire        period_end = (phase_reg == cyc_reg - 16'h0001);
   wire [15:0] new_cyc    = ctl[`CT_UPD_CYC] ? cycle_in : cyc_reg;
   wire [15:0] new_wid    = ctl[`CT_UPD_WID] ? width_in : wid_reg;
   wire [31:0] new_cnt    = ctl[`CT_UPD_CNT] ? count_in : cnt_last_reg;

   // Idle means no pulse train in progress.
   assign busy = run_reg & ~pwm_reg; // R5

   // Parameters are taken only at exec, so plain register writes never
   // disturb a running output.
   always @(posedge ref_clk) begin
      if (rst) begin
         run_reg      <= 1'b0;
         pwm_reg      <= 1'b0;
         tb_reg       <= 1'b0;
         cyc_reg      <= `CYC_MIN;
         wid_reg      <= `RST_WORD;
         phase_reg    <= `RST_WORD;
         left_reg     <= `RST_DWORD;
         cnt_last_reg <= `RST_DWORD;
         pend_reg     <= 1'b0;
         pend_cyc_reg <= `CYC_MIN;
         pend_wid_reg <= `RST_WORD;
         pend_cnt_reg <= `RST_DWORD;
         pulse_out    <= 1'b0;
         delta_ev     <= 1'b0;
         user_ev      <= 1'b0;
         ovf_ev       <= 1'b0;
      end else begin
         delta_ev <= 1'b0;
         user_ev  <= 1'b0;
         ovf_ev   <= 1'b0;
         if (exec) begin // R18
            if (!ctl[`CT_EN]) begin // R13
               user_ev  <= run_reg & ~pwm_reg; // R3
               run_reg  <= 1'b0;
               pend_reg <= 1'b0;
            end else if (ctl[`CT_PWM]) begin // R12
               tb_reg  <= ctl[`CT_TB]; // R9
               pwm_reg <= 1'b1;
               if (run_reg && pwm_reg && ctl[`CT_SYNC]) begin // R10 R19
                  pend_reg     <= 1'b1;
                  pend_cyc_reg <= new_cyc; // R6
                  pend_wid_reg <= new_wid; // R7 R15
               end else begin // R19
                  cyc_reg   <= new_cyc;
                  wid_reg   <= new_wid;
                  phase_reg <= `RST_WORD;
                  run_reg   <= 1'b1;
                  pend_reg  <= 1'b0;
               end
            end else if (new_cyc < `CYC_MIN || new_cnt == `CNT_ZERO) begin
               delta_ev <= 1'b1; // R2 R14 R16
            end else if (run_reg && !pwm_reg) begin
               // A second train queues behind the running one.
               if (pend_reg) begin
                  ovf_ev <= 1'b1; // R4
               end else begin
                  pend_reg     <= 1'b1;
                  pend_cyc_reg <= new_cyc;
                  pend_cnt_reg <= new_cnt;
               end
               cnt_last_reg <= new_cnt;
            end else begin // R11
               tb_reg       <= ctl[`CT_TB];
               pwm_reg      <= 1'b0;
               cyc_reg      <= new_cyc; // R6
               left_reg     <= new_cnt; // R8
               cnt_last_reg <= new_cnt;
               phase_reg    <= `RST_WORD;
               run_reg      <= 1'b1;
               pend_reg     <= 1'b0;
            end
         end else if (run_reg && tick) begin
            if (period_end) begin
               phase_reg <= `RST_WORD;
               if (pwm_reg) begin
                  if (pend_reg) begin // R19
                     cyc_reg  <= pend_cyc_reg;
                     wid_reg  <= pend_wid_reg;
                     pend_reg <= 1'b0;
                  end
               end else if (left_reg == 32'h0000_0001) begin // R16
                  if (pend_reg) begin
                     cyc_reg  <= pend_cyc_reg;
                     left_reg <= pend_cnt_reg;
                     pend_reg <= 1'b0;
                  end else begin
                     run_reg <= 1'b0;
                  end
               end else begin
                  left_reg <= left_reg - 32'h0000_0001;
               end
            end else begin
               phase_reg <= phase_reg + 16'h0001;
            end
         end
         // Pulse train runs at half duty; the output lags phase by a cycle.
         if (!run_reg) begin
            pulse_out <= 1'b0; // R13
         end else if (pwm_reg) begin
            pulse_out <= (phase_reg < wid_reg); // R15
         end else begin
            pulse_out <= (phase_reg < {1'b0, cyc_reg[15:1]});
         end
      end
   end

endmodule // pulse_gen
`default_nettype wire

/* rtl/dummy_unused_none.v */
`default_nettype none
`default_nettype wire

/* bench/pulse_out_checker.sv */
// Concurrent checks on the bus and pin ports of the dual pulse block.
// Assumes it is bound into pulse_out_top and sees only its ports.
`default_nettype none

module pulse_out_checker (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        pulse_out0,
   input wire logic        pulse_out1
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // Requests taken at an edge; the answer lands one cycle later.
   wire logic take    = (avs_read | avs_write) & avs_waitrequest;
   wire logic rd_take = avs_read & avs_waitrequest;

   a_wait_answer: assert property (take |=> !avs_waitrequest)
      else $error("bus answer missing one cycle after request");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer held longer than one cycle");
   a_wait_noreq: assert property
      (!(avs_read | avs_write) && avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer without a request");
   // Everything must be quiet on the first edge after reset.
   a_reset_quiet: assert property ($fell(rst) |-> avs_waitrequest &&
      !pulse_out0 && !pulse_out1 && avs_readdata == 32'h0000_0000)
      else $error("outputs not quiet after reset");
   a_unmapped_zero: assert property (rd_take && avs_address < 8'h42 |=>
      avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_exec_zero: assert property (rd_take && avs_address == 8'h56 |=>
      avs_readdata == 32'h0000_0000)
      else $error("command register read not zero");
   a_status_rsvd: assert property (rd_take && (avs_address == 8'h42 ||
      avs_address == 8'h4C) |=> avs_readdata[31:8] == 24'h000000 &&
      avs_readdata[3:0] == 4'h0)
      else $error("status reserved bits set");
   a_ctl_upper: assert property (rd_take && (avs_address == 8'h43 ||
      avs_address == 8'h4D) |=> avs_readdata[31:8] == 24'h000000)
      else $error("control upper bits set");
   a_word_upper: assert property (rd_take && (avs_address == 8'h44 ||
      avs_address == 8'h4E || avs_address == 8'h46 ||
      avs_address == 8'h50) |=> avs_readdata[31:16] == 16'h0000)
      else $error("word register upper bits set");

   c_status_read: cover property (rd_take && avs_address == 8'h42);
   c_out0_rise: cover property ($rose(pulse_out0));
   c_out1_rise: cover property ($rose(pulse_out1));
endmodule // pulse_out_checker

bind pulse_out_top pulse_out_checker chk (.ref_clk, .rst, .avs_address,
   .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .pulse_out0,
   .pulse_out1);
`default_nettype wire

/* bench/pulse_load.sv */
// Load on one pulse output pin: counts rises and times the last high
// phase and period in clock cycles. Assumes the block's reference clock.
`default_nettype none

module pulse_load (
   input  wire logic ref_clk,
   input  wire logic pin,
   output var  int   rises,
   output var  int   high_len,
   output var  int   period_len
);
   timeunit 1ns;
   timeprecision 1ps;
   int   hi_cnt;
   int   per_cnt;
   logic pin_q;

   initial begin
      rises = 0;
      high_len = 0;
      period_len = 0;
      hi_cnt = 0;
      per_cnt = 0;
      pin_q = 1'b0;
   end

   // Edge timing; a stuck pin shows as a stale rise count, not a hang.
   always @(posedge ref_clk) begin
      pin_q <= pin;
      per_cnt <= per_cnt + 1;
      hi_cnt <= hi_cnt + 1;
      if (pin && !pin_q) begin
         rises <= rises + 1;
         period_len <= per_cnt;
         per_cnt <= 1;
         hi_cnt <= 1;
      end
      if (!pin && pin_q)
         high_len <= hi_cnt;
   end
endmodule // pulse_load
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the dual pulse block: register table, trains,
// modulation and status flags. Assumes a 40 MHz clock and word indices.
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      bit          wr;
      logic [7:0]  a;
      logic [31:0] d;
      logic [3:0]  be;
      logic [31:0] e;
   } row_t;
   logic        ref_clk;
   logic        rst;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        pulse_out0;
   logic        pulse_out1;
   logic [31:0] rd;
   int          n_mismatch;
   int          tests_run;
   int          cycles;
   int          r0;
   int          rises0, high0, per0, rises1, high1, per1;
   row_t        rows [19];

   pulse_out_top DUT (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .pulse_out0, .pulse_out1);
   pulse_load load0 (.ref_clk, .pin(pulse_out0), .rises(rises0),
      .high_len(high0), .period_len(per0));
   pulse_load load1 (.ref_clk, .pin(pulse_out1), .rises(rises1),
      .high_len(high1), .period_len(per1));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Hang guard: the whole run needs well under this many cycles.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch = n_mismatch + 1;
         close_out;
      end
   end

   task automatic close_out;
      $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk_reg(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   task automatic chk_cnt(input string nm, input int e, g);
      tests_run++;
      if (g != e) begin
         n_mismatch++;
         $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
      end
   endtask

   // One Avalon access; held until waitrequest is seen low at an edge.
   task automatic bus(input bit w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_read       <= !w;
      avs_write      <= w;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hF);
      chk_reg($sformatf("register %h", a), e, rd);
   endtask

   // Polls a status byte until its idle flag comes back.
   task automatic wait_idle(input logic [7:0] a);
      do bus(1'b0, a, 32'h0, 4'hF); while (rd[7] !== 1'b1);
   endtask

   // One modulation step on the second generator, then pin timing.
   task automatic mod_step(input logic [31:0] w, c, input bit ex,
                           input int eh);
      wr(8'h50, w);
      if (ex) begin
         wr(8'h4D, c);
         wr(8'h56, 32'h2);
      end
      repeat (900) @(posedge ref_clk);
      chk_cnt("high1", eh, high1);
      chk_cnt("period1", 400, per1);
   endtask

   initial begin
      rst = 1'b1;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      n_mismatch = 0;
      tests_run = 0;
      cycles = 0;
      rows = '{'{0, 8'h42, 32'h0, 4'h0, 32'h80},
               '{0, 8'h43, 32'h0, 4'h0, 32'h0},
               '{0, 8'h44, 32'h0, 4'h0, 32'h2},
               '{0, 8'h46, 32'h0, 4'h0, 32'h0},
               '{0, 8'h48, 32'h0, 4'h0, 32'h0},
               '{0, 8'h4C, 32'h0, 4'h0, 32'h80},
               '{0, 8'h4D, 32'h0, 4'h0, 32'h0},
               '{0, 8'h4E, 32'h0, 4'h0, 32'h2},
               '{0, 8'h50, 32'h0, 4'h0, 32'h0},
               '{0, 8'h52, 32'h0, 4'h0, 32'h0},
               '{0, 8'h00, 32'h0, 4'h0, 32'h0},
               '{0, 8'h56, 32'h0, 4'h0, 32'h0},
               '{1, 8'h44, 32'hFFFF0005, 4'hF, 32'h5},
               '{1, 8'h48, 32'h12345678, 4'hF, 32'h12345678},
               '{1, 8'h4D, 32'h48, 4'hF, 32'h48},
               '{1, 8'h4C, 32'hFFFFFFFF, 4'hF, 32'h80},
               '{1, 8'h50, 32'h0000BEEF, 4'hF, 32'hBEEF},
               '{1, 8'h52, 32'hAABBCCDD, 4'h3, 32'hCCDD},
               '{1, 8'h55, 32'hFFFFFFFF, 4'hF, 32'h0}};
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].wr)
            bus(1'b1, rows[i].a, rows[i].d, rows[i].be);
         rdchk(rows[i].a, rows[i].e);
      end
      // Three-pulse train of 4 us period on the first generator.
      wr(8'h44, 32'h4);
      wr(8'h48, 32'h3);
      wr(8'h43, 32'h85);
      wr(8'h56, 32'h1);
      rdchk(8'h42, 32'h00);
      wait_idle(8'h42);
      chk_cnt("pulses0", 3, rises0);
      chk_cnt("high0", 80, high0);
      chk_cnt("period0", 160, per0);
      // A zero count must be refused and flagged, not run.
      wr(8'h52, 32'h0);
      wr(8'h4D, 32'h85);
      wr(8'h56, 32'h2);
      rdchk(8'h4C, 32'h90);
      chk_cnt("pulses1", 0, rises1);
      wr(8'h4C, 32'h0);
      rdchk(8'h4C, 32'h80);
      // Disable in mid-train: abort flag, then the pin falls silent.
      wr(8'h48, 32'h64);
      wr(8'h43, 32'h85);
      wr(8'h56, 32'h1);
      repeat (200) @(posedge ref_clk);
      wr(8'h43, 32'h0);
      wr(8'h56, 32'h1);
      rdchk(8'h42, 32'hA0);
      r0 = rises0;
      repeat (400) @(posedge ref_clk);
      chk_cnt("halted0", r0, rises0);
      // Third command while one is queued overflows the pipeline.
      wr(8'h42, 32'h0);
      wr(8'h43, 32'h85);
      repeat (3) wr(8'h56, 32'h1);
      rdchk(8'h42, 32'h40);
      wr(8'h43, 32'h20);
      wr(8'h56, 32'h1);
      rdchk(8'h42, 32'hA0);
      wr(8'h42, 32'h0);
      // Modulation on the second generator: load, stale, sync, async.
      wr(8'h4E, 32'hA);
      mod_step(32'h3, 32'hC3, 1'b1, 120);
      mod_step(32'h6, 32'h0, 1'b0, 120);
      mod_step(32'h6, 32'hD2, 1'b1, 240);
      mod_step(32'h2, 32'hC2, 1'b1, 80);
      // Millisecond base: no second rise can come within 2000 cycles.
      wr(8'h4E, 32'h2);
      wr(8'h50, 32'h1);
      wr(8'h4D, 32'hCB);
      wr(8'h56, 32'h2);
      repeat (100) @(posedge ref_clk);
      r0 = rises1;
      repeat (2000) @(posedge ref_clk);
      chk_cnt("slow1", r0, rises1);
      wr(8'h4D, 32'h0);
      wr(8'h56, 32'h2);
      repeat (4) @(posedge ref_clk);
      chk_reg("pin1", 32'h0, {31'h0, pulse_out1});
      // Reset in mid-train returns pin and registers to their defaults.
      wr(8'h43, 32'h85);
      wr(8'h56, 32'h1);
      repeat (60) @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      chk_reg("pin0", 32'h0, {31'h0, pulse_out0});
      rdchk(8'h42, 32'h80);
      rdchk(8'h44, 32'h2);
      close_out;
   end
endmodule // tb_top
`default_nettype wire
